// file: common/lsbp_consts.svh
// offsets, field positions, reset values and masks of the low-bit and pin config registers
`ifndef LSBP_CONSTS_SVH
`define LSBP_CONSTS_SVH
`define LSBP_ADDR_ALERT_MASK2 8'h75
`define LSBP_ADDR_VOLT_LOW 8'h76
`define LSBP_ADDR_TEMP_LOW 8'h77
`define LSBP_ADDR_PIN_CFG 8'h78
`define LSBP_ADDR_HIGH_BASE 8'h20
`define LSBP_ADDR_HIGH_LAST 8'h27
`define LSBP_RST_ALERT_MASK2 8'h00
`define LSBP_RST_PIN_CFG 8'h00
`define LSBP_WMASK_ALERT_MASK2 8'hfd
`define LSBP_CFG_ALERT_BIT 0
`define LSBP_CFG_OVERTEMP_FLAG_PIN_BIT 1
`define LSBP_CFG_BOOST_BIT 2
`define LSBP_FUNC_FAN4 2'h0
`define LSBP_FUNC_OVERTEMP_FLAG_PIN 2'h1
`define LSBP_FUNC_ALERT 2'h2
`define LSBP_NUM_CH 8
`define LSBP_VOLT_CH 4
`endif

// file: common/lsbp_pkg.sv
// types shared by the low-bit and pin config register logic
package lsbp_pkg;
  typedef logic [9:0] lsbp_meas_t;
  typedef logic [7:0] lsbp_byte_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lsbp_req_s;
  typedef struct packed {
    logic alert_n;
    logic fan2_pwm;
    logic fan_running;
    logic timer_en;
  } lsbp_sys_s;
  typedef enum {lsbp_pin14_fan4, lsbp_pin14_overtemp_flag_pin, lsbp_pin14_alert, lsbp_pin14_gpio} lsbp_pin14_e;
endpackage : lsbp_pkg

// file: logic/lsbp_regs.sv
// low-bit readout registers with freeze, and shared pin function configuration
`timescale 1ns/10ps
`include "lsbp_consts.svh"
module lsbp_regs (
  input wire logic sys_clk, // 100 MHz clock
  input wire logic reset_n, // async reset, active low
  input wire logic clk_en, // freezes all state when low
  input lsbp_pkg::lsbp_req_s req, // register read/write request
  input lsbp_pkg::lsbp_meas_t [7:0] readings, // 10-bit readings, ch 0..7
  input lsbp_pkg::lsbp_sys_s sys, // alert request, fan 2 drive, fan state
  input wire logic [1:0] multipurpose_pin_function, // multipurpose pin code
  input wire logic [2:0] overtemp_out_cfg, // nonzero makes overtemp pin bidirectional
  input wire logic overtemp_req, // core asks to drive overtemp low
  input wire logic overtemp_flag_pin_in, // dedicated overtemp pin level
  input wire logic mp_pin_in, // multipurpose pin level
  output lsbp_pkg::lsbp_byte_t rdata, // read data, one cycle after rd
  output logic overtemp_flag_pin_out, // dedicated pin drive level
  output logic overtemp_flag_pin_oe, // dedicated pin drive enable
  output logic meas_2v5_en, // dedicated pin used as 2.5V input
  output logic shared_pin_out, // alert or fan2_pulse_drive pin
  output logic mp_pin_out, // multipurpose pin drive level
  output logic mp_pin_oe, // multipurpose pin drive enable
  output lsbp_pkg::lsbp_pin14_e mp_mode, // multipurpose pin function
  output logic fans_full, // run all fans at full speed
  output logic [15:0] overtemp_time // cycles of overtemp asserted
);
  import lsbp_pkg::*;

  lsbp_meas_t snap [`LSBP_NUM_CH];
  logic [`LSBP_NUM_CH-1:0] frozen;
  logic [`LSBP_NUM_CH-1:0] freeze_set;
  logic [`LSBP_NUM_CH-1:0] freeze_clr;
  lsbp_byte_t alert_mask_second;
  lsbp_byte_t pin_function_config;
  logic overtemp_act;

  function automatic logic is_high(input logic [7:0] a);
    is_high = (a >= `LSBP_ADDR_HIGH_BASE) && (a <= `LSBP_ADDR_HIGH_LAST);
  endfunction : is_high

  function automatic logic [2:0] chan_of(input logic [7:0] a);
    logic [7:0] d;
    d = a - `LSBP_ADDR_HIGH_BASE;
    chan_of = d[2:0];
  endfunction : chan_of

  ////////////////////////////////////////////////////////////////////////////
  // freeze control
  always_comb begin
    freeze_set = '0;
    freeze_clr = '0;
    for (int i = 0; i < `LSBP_NUM_CH; i++) begin
      if (req.rd && req.addr == `LSBP_ADDR_VOLT_LOW && i < `LSBP_VOLT_CH) begin
        freeze_set[i] = 1'b1;
      end
      if (req.rd && req.addr == `LSBP_ADDR_TEMP_LOW && i >= `LSBP_VOLT_CH) begin
        freeze_set[i] = 1'b1;
      end
      if (req.rd && is_high(req.addr) && chan_of(req.addr) == 3'(i)) begin
        freeze_clr[i] = 1'b1;
      end
    end
  end

  // a new freeze wins over a release in the same cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      frozen <= '0;
    end else if (clk_en) begin
      frozen <= freeze_set | (frozen & ~freeze_clr);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < `LSBP_NUM_CH; i++) begin
        snap[i] <= '0;
      end
    end else if (clk_en) begin
      for (int i = 0; i < `LSBP_NUM_CH; i++) begin
        if (!frozen[i] && !freeze_set[i]) begin
          snap[i] <= readings[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      alert_mask_second <= `LSBP_RST_ALERT_MASK2;
      pin_function_config <= `LSBP_RST_PIN_CFG;
    end else if (clk_en && req.wr) begin
      // low-bit registers have no write path
      if (req.addr == `LSBP_ADDR_ALERT_MASK2) begin
        alert_mask_second <= req.wdata & `LSBP_WMASK_ALERT_MASK2;
      end
      if (req.addr == `LSBP_ADDR_PIN_CFG) begin
        pin_function_config <= req.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= '0;
    end else if (clk_en && req.rd) begin
      if (req.addr == `LSBP_ADDR_VOLT_LOW) begin
        rdata <= {snap[3][1:0], snap[2][1:0], snap[1][1:0], snap[0][1:0]};
      end else if (req.addr == `LSBP_ADDR_TEMP_LOW) begin
        rdata <= {snap[7][1:0], snap[6][1:0], snap[5][1:0], snap[4][1:0]};
      end else if (req.addr == `LSBP_ADDR_ALERT_MASK2) begin
        rdata <= alert_mask_second;
      end else if (req.addr == `LSBP_ADDR_PIN_CFG) begin
        rdata <= pin_function_config;
      end else if (is_high(req.addr)) begin
        rdata <= snap[chan_of(req.addr)][9:2];
      end else begin
        rdata <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared pin functions
  wire logic overtemp_flag_pin_sel = pin_function_config[`LSBP_CFG_OVERTEMP_FLAG_PIN_BIT];
  wire logic alert_sel = pin_function_config[`LSBP_CFG_ALERT_BIT];
  wire logic boost = pin_function_config[`LSBP_CFG_BOOST_BIT];
  wire logic mp_overtemp_flag_pin = multipurpose_pin_function == `LSBP_FUNC_OVERTEMP_FLAG_PIN;

  assign overtemp_act = (overtemp_flag_pin_sel && !overtemp_flag_pin_in) || (mp_overtemp_flag_pin && !mp_pin_in);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      shared_pin_out <= 1'b1;
      meas_2v5_en <= 1'b1;
      overtemp_flag_pin_out <= 1'b1;
      overtemp_flag_pin_oe <= 1'b0;
    end else if (clk_en) begin
      shared_pin_out <= alert_sel ? sys.alert_n : sys.fan2_pwm;
      meas_2v5_en <= !overtemp_flag_pin_sel;
      overtemp_flag_pin_out <= 1'b0;
      overtemp_flag_pin_oe <= overtemp_flag_pin_sel && (overtemp_out_cfg != 3'h0) && overtemp_req;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mp_mode <= lsbp_pin14_fan4;
      mp_pin_out <= 1'b1;
      mp_pin_oe <= 1'b0;
    end else if (clk_en) begin
      case (multipurpose_pin_function)
        `LSBP_FUNC_FAN4: begin
          mp_mode <= lsbp_pin14_fan4;
          mp_pin_out <= 1'b1;
          mp_pin_oe <= 1'b0;
        end
        `LSBP_FUNC_OVERTEMP_FLAG_PIN: begin
          mp_mode <= lsbp_pin14_overtemp_flag_pin;
          mp_pin_out <= 1'b0;
          mp_pin_oe <= (overtemp_out_cfg != 3'h0) && overtemp_req;
        end
        `LSBP_FUNC_ALERT: begin
          mp_mode <= lsbp_pin14_alert;
          mp_pin_out <= 1'b0;
          mp_pin_oe <= !sys.alert_n;
        end
        default: begin
          mp_mode <= lsbp_pin14_gpio;
          mp_pin_out <= 1'b1;
          mp_pin_oe <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // boost and overtemp timer
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fans_full <= 1'b0;
    end else if (clk_en) begin
      fans_full <= overtemp_act && sys.fan_running && boost;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      overtemp_time <= '0;
    end else if (clk_en && sys.timer_en && overtemp_act) begin
      overtemp_time <= overtemp_time + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_volt_low;
    @(posedge sys_clk) disable iff (!reset_n)
    clk_en && req.rd && req.addr == `LSBP_ADDR_VOLT_LOW |=>
      rdata == {$past(snap[3][1:0]), $past(snap[2][1:0]), $past(snap[1][1:0]), $past(snap[0][1:0])};
  endproperty
  a_volt_low: assert property (p_volt_low) else $error("voltage low bits wrong");

  property p_freeze_set;
    @(posedge sys_clk) disable iff (!reset_n)
    clk_en && req.rd && req.addr == `LSBP_ADDR_TEMP_LOW |=> frozen[7:4] == 4'hf;
  endproperty
  a_freeze_set: assert property (p_freeze_set) else $error("freeze not set");

  property p_freeze_hold;
    @(posedge sys_clk) disable iff (!reset_n)
    frozen[0] |=> snap[0] == $past(snap[0]);
  endproperty
  a_freeze_hold: assert property (p_freeze_hold) else $error("frozen reading moved");

  property p_temp_low;
    @(posedge sys_clk) disable iff (!reset_n)
    clk_en && req.rd && req.addr == `LSBP_ADDR_TEMP_LOW |=>
      rdata[1:0] == $past(snap[4][1:0]) && rdata[7:6] == $past(snap[7][1:0]);
  endproperty
  a_temp_low: assert property (p_temp_low) else $error("temperature low bits wrong");

  property p_shared_pin;
    @(posedge sys_clk) disable iff (!reset_n)
    clk_en && alert_sel && !sys.alert_n |=> !shared_pin_out;
  endproperty
  a_shared_pin: assert property (p_shared_pin) else $error("alert not on shared pin");

  property p_boost;
    @(posedge sys_clk) disable iff (!reset_n)
    clk_en && overtemp_act && sys.fan_running && boost |=> fans_full;
  endproperty
  a_boost: assert property (p_boost) else $error("boost did not run fans full");

  property p_timer;
    @(posedge sys_clk) disable iff (!reset_n)
    clk_en && sys.timer_en && overtemp_act |=> overtemp_time == 16'($past(overtemp_time) + 1);
  endproperty
  a_timer: assert property (p_timer) else $error("overtemp timer did not count");

  property p_2v5;
    @(posedge sys_clk) disable iff (!reset_n)
    clk_en && !overtemp_flag_pin_sel |=> meas_2v5_en && !overtemp_flag_pin_oe;
  endproperty
  a_2v5: assert property (p_2v5) else $error("dedicated pin not a 2.5V input");

  property p_input_only;
    @(posedge sys_clk) disable iff (!reset_n)
    clk_en && overtemp_out_cfg == 3'h0 |=> !overtemp_flag_pin_oe;
  endproperty
  a_input_only: assert property (p_input_only) else $error("overtemp pin driven as input");
endmodule : lsbp_regs

// file: test/lsbp_host.sv
// host model issuing register reads and writes on the request port
`timescale 1ns/10ps
module lsbp_host (
  input wire logic sys_clk, // bench clock
  input lsbp_pkg::lsbp_byte_t rdata, // read data from the block
  output lsbp_pkg::lsbp_req_s req // request to the block
);
  import lsbp_pkg::*;
  initial req = '0;
  ////////////////////
  // released address and data show the inverse of the last value
  task automatic reg_write(input lsbp_byte_t a, input lsbp_byte_t v);
    @(negedge sys_clk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
    @(negedge sys_clk);
    req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~v};
  endtask : reg_write
  task automatic reg_read(input lsbp_byte_t a, output lsbp_byte_t dout);
    @(negedge sys_clk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge sys_clk);
    req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
    @(negedge sys_clk);
    dout = rdata;
  endtask : reg_read
endmodule : lsbp_host

// file: test/tb.sv
// self-checking bench for the low-bit readout and pin config registers
`timescale 1ns/10ps
`include "lsbp_consts.svh"
module tb;
  import lsbp_pkg::*;
  logic sys_clk, reset_n, clk_en, otreq, ot_lvl;
  lsbp_req_s req;
  lsbp_meas_t [7:0] rv, old;
  lsbp_sys_s sys_in;
  logic [1:0] mpf;
  logic [2:0] ocfg;
  lsbp_byte_t rdata, d;
  logic ot_out, ot_oe, m25, shp, mp_out, mp_oe, ffull;
  lsbp_pin14_e mode;
  logic [15:0] ot_time, t0;
  int err_total, comparisons;
  // multipurpose pin pulled up when nobody drives; dedicated pin then follows ot_lvl
  wire ot_pin = ot_oe ? ot_out : ot_lvl;
  wire mp_in = mp_oe ? mp_out : 1'b1;
  lsbp_host host (.sys_clk(sys_clk), .rdata(rdata), .req(req));
  lsbp_regs dut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .req(req),
    .readings(rv), .sys(sys_in), .multipurpose_pin_function(mpf), .overtemp_out_cfg(ocfg),
    .overtemp_req(otreq), .overtemp_flag_pin_in(ot_pin), .mp_pin_in(mp_in), .rdata(rdata),
    .overtemp_flag_pin_out(ot_out), .overtemp_flag_pin_oe(ot_oe), .meas_2v5_en(m25),
    .shared_pin_out(shp), .mp_pin_out(mp_out), .mp_pin_oe(mp_oe), .mp_mode(mode),
    .fans_full(ffull), .overtemp_time(ot_time));
  ////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  task automatic chk_byte(input lsbp_byte_t got, input lsbp_byte_t exp, input string m);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic got, input logic exp, input string m);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask : chk_bit
  task automatic rd_chk(input lsbp_byte_t a, input lsbp_byte_t exp, input string m);
    host.reg_read(a, d);
    chk_byte(d, exp, m);
  endtask : rd_chk
  task automatic cfg(input lsbp_byte_t v);
    host.reg_write(`LSBP_ADDR_PIN_CFG, v);
    cyc(3);
  endtask : cfg
  function automatic lsbp_byte_t lows(input int g);
    return {old[4*g+3][1:0], old[4*g+2][1:0], old[4*g+1][1:0], old[4*g][1:0]};
  endfunction : lows
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  ////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #200000;
    err_total++;
    test_done();
  end
  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    otreq = 1'b0;
    ot_lvl = 1'b1;
    mpf = `LSBP_FUNC_FAN4;
    ocfg = 3'h0;
    sys_in = '{alert_n: 1'b1, fan2_pwm: 1'b0, fan_running: 1'b0, timer_en: 1'b0};
    err_total = 0;
    comparisons = 0;
    for (int i = 0; i < 8; i++) rv[i] = {8'h40 + 8'(i), 2'(i < 4 ? 3 - i : i ^ 1)};
    old = rv;
    cyc(12);
    reset_n = 1'b1;
    rd_chk(`LSBP_ADDR_ALERT_MASK2, `LSBP_RST_ALERT_MASK2, "mask reset");
    rd_chk(`LSBP_ADDR_PIN_CFG, `LSBP_RST_PIN_CFG, "cfg reset");
    host.reg_write(`LSBP_ADDR_ALERT_MASK2, 8'hff);
    rd_chk(`LSBP_ADDR_ALERT_MASK2, 8'hfd, "mask bit 1");
    clk_en = 1'b0;
    host.reg_write(`LSBP_ADDR_ALERT_MASK2, 8'h00);
    clk_en = 1'b1;
    rd_chk(`LSBP_ADDR_ALERT_MASK2, 8'hfd, "enable low");
    rd_chk(8'h10, 8'h00, "unmapped");
    $display("test registers done");
    for (int g = 0; g < 2; g++) begin
      host.reg_write(`LSBP_ADDR_VOLT_LOW + 8'(g), 8'h00);
      rd_chk(`LSBP_ADDR_VOLT_LOW + 8'(g), lows(g), "low bits");
      for (int i = 0; i < 8; i++) rv[i] = old[i] ^ 10'h3ff;
      for (int c = 4 * g; c < 4 * g + 4; c++) begin
        rd_chk(`LSBP_ADDR_HIGH_BASE + 8'(c), old[c][9:2], "frozen");
      end
      rd_chk(`LSBP_ADDR_HIGH_BASE + 8'(4 * g), rv[4*g][9:2], "released");
      rv = old;
      cyc(2);
    end
    $display("test freeze done");
    for (int k = 0; k < 4; k++) begin
      sys_in.alert_n = k[1];
      sys_in.fan2_pwm = ~k[1];
      cfg({7'h0, k[0]});
      chk_bit(shp, k[0] ? k[1] : ~k[1], "shared pin");
    end
    cfg(8'h00);
    chk_bit(m25, 1'b1, "2v5 input");
    for (int f = 0; f < 4; f++) begin
      mpf = 2'(f);
      cyc(3);
      chk_byte(8'(mode), 8'(f), "mp mode");
    end
    mpf = `LSBP_FUNC_FAN4;
    otreq = 1'b1;
    cfg(8'h02);
    chk_bit(m25, 1'b0, "2v5 off");
    chk_bit(ot_oe, 1'b0, "input only");
    ocfg = 3'h5;
    cyc(3);
    chk_bit(ot_pin, 1'b0, "driven");
    ocfg = 3'h0;
    otreq = 1'b0;
    ot_lvl = 1'b0;
    sys_in.fan_running = 1'b1;
    sys_in.timer_en = 1'b1;
    cfg(8'h06);
    chk_bit(ffull, 1'b1, "boost");
    t0 = ot_time;
    cyc(10);
    chk_byte(8'(ot_time - t0), 8'h0a, "timer");
    cfg(8'h04);
    chk_bit(ffull, 1'b0, "overtemp_flag_pin off");
    cfg(8'h02);
    chk_bit(ffull, 1'b0, "no boost");
    ot_lvl = 1'b1;
    otreq = 1'b1;
    mpf = `LSBP_FUNC_OVERTEMP_FLAG_PIN;
    cfg(8'h04);
    chk_bit(mp_in, 1'b1, "mp input only");
    chk_bit(ot_oe, 1'b0, "overtemp_flag_pin off no drive");
    ocfg = 3'h3;
    cyc(3);
    chk_bit(mp_in, 1'b0, "mp driven");
    chk_bit(ffull, 1'b1, "mp boost");
    mpf = `LSBP_FUNC_ALERT;
    sys_in.alert_n = 1'b0;
    cyc(3);
    chk_bit(mp_in, 1'b0, "mp alert");
    chk_bit(ffull, 1'b0, "mp alert no boost");
    $display("test pins done");
    test_done();
  end
endmodule : tb
